/* File: urf_flag_monitor.sv */
// Notes on behaviour
// - non-held flags clear on next packet
// - valid addressed token sets bit 6
// - line state sets bits 5, 4, 3
// - data crc16 failure sets bit 2
// - bits 1, 0 follow rxactive, rxerror
// - held flags stay until written one
// - non-held bits 5, 4, 3, 1, 0 overwritten by later changes
// - four masks OR flags onto ports
// - eleven-bit frame number loaded on sof, software read/write
// - last packet identifier captured, read only
// - last endpoint copied, bit 4 valid
// - marked endpoints ORed with 0x10 outward
// - seven-bit device address filters tokens
// - line decode only when control bit set
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns
module urf_flag_monitor
  import urf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] utmi_linestate_i,
  input wire logic utmi_rxactive_i,
  input wire logic utmi_rxerror_i,
  input wire logic pkt_start_i,
  input wire logic pid_valid_i,
  input wire logic [3:0] pid_i,
  input wire logic tok_i,
  input wire logic tok_crc5_ok_i,
  input wire logic tok_pid_ok_i,
  input wire logic [6:0] tok_addr_i,
  input wire logic [3:0] tok_ep_i,
  input wire logic data_crc16_fail_i,
  input wire logic sof_i,
  input wire logic [10:0] sof_frame_i,
  output logic flag_out_port_a_o,
  output logic flag_out_port_b_o,
  output logic flag_out_port_c_o,
  output logic flag_out_port_d_o,
  output logic [4:0] rx_ep_o,
  output logic rx_ep_valid_o
);

  typedef struct packed {
    logic [6:0] flags;
    logic [6:0] hold;
    logic [31:0] masks;
    logic [10:0] frame;
    logic [3:0] last_packet_id;
    logic [3:0] ep;
    logic ep_valid;
    logic [15:0] marking;
    logic line_state_decode_enable;
    logic [6:0] dev_addr;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
    logic [3:0] port;
    logic ack;
    logic [31:0] rdat;
    logic [4:0] rx_ep;
    logic rx_v;
  } urf_state_s;

  urf_state_s r;
  urf_state_s n;

  function automatic logic [31:0] urf_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  logic req;
  logic wr;
  logic tok_ok;
  logic [6:0] ev;
  logic [6:0] clr;
  logic [3:0] port_n;
  logic mark_bit;
  logic [1:0] ls;
  logic [31:0] rd_word;
  logic [31:0] wr_word;

  assign req = wb_cyc_i & wb_stb_i;
  // writes land on the ack edge, when the master samples it
  assign wr = req & wb_we_i & r.ack;
  assign ls = r.filt[3:2];
  assign tok_ok = tok_i & tok_crc5_ok_i & tok_pid_ok_i & (tok_addr_i == r.dev_addr);
  assign mark_bit = r.marking[tok_ep_i];
  assign clr = (wr && wb_adr_i == URF_OFS_FLAGS && wb_sel_i[0]) ? wb_dat_i[6:0] : 7'h00;

  always_comb
  begin
    ev = 7'h00;
    ev[URF_F_TOKEN] = tok_ok;
    ev[URF_F_SE0] = r.line_state_decode_enable & (ls == URF_LS_SE0);
    ev[URF_F_K] = r.line_state_decode_enable & (ls == URF_LS_K);
    ev[URF_F_J] = r.line_state_decode_enable & (ls == URF_LS_J);
    ev[URF_F_CRC] = data_crc16_fail_i;
    ev[URF_F_RXA] = r.filt[1];
    ev[URF_F_RXE] = r.filt[0];
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_port
      assign port_n[g] = |(r.flags & r.masks[g*8 +: URF_NFLAG]);
    end
  endgenerate

  always_comb
  begin
    n = r;
    n.ack = req & ~r.ack;
    n.rx_v = 1'b0;
    n.port = port_n;
    n.s1 = {utmi_linestate_i, utmi_rxactive_i, utmi_rxerror_i};
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < 4; i++)
    begin
      if (r.s2[i] == r.s3[i])
      begin
        n.filt[i] = r.s2[i];
      end
    end
    for (int i = 0; i < URF_NFLAG; i++)
    begin
      // set wins over any clear in the same cycle
      if (ev[i])
      begin
        n.flags[i] = 1'b1;
      end
      else if (r.hold[i])
      begin
        n.flags[i] = r.flags[i] & ~clr[i];
      end
      else if (URF_LEVEL_FLAGS[i] || pkt_start_i || clr[i])
      begin
        n.flags[i] = 1'b0;
      end
    end
    if (pid_valid_i)
    begin
      n.last_packet_id = pid_i;
    end
    if (sof_i)
    begin
      n.frame = sof_frame_i;
    end
    if (tok_ok)
    begin
      n.ep = tok_ep_i;
      n.ep_valid = 1'b1;
      n.rx_ep = {1'b0, tok_ep_i} | (mark_bit ? URF_MARK_OR : 5'h00);
      n.rx_v = 1'b1;
    end
    if (wr)
    begin
      if (wb_adr_i == URF_OFS_CTRL)
      begin
        n.line_state_decode_enable = wr_word[URF_CTRL_DEC_BIT];
      end
      else if (wb_adr_i == URF_OFS_ADDR)
      begin
        n.dev_addr = wr_word[6:0];
      end
      else if (wb_adr_i == URF_OFS_HOLD)
      begin
        n.hold = wr_word[6:0];
      end
      else if (wb_adr_i == URF_OFS_MASK)
      begin
        n.masks = wr_word;
      end
      // software write beats a sof load in the same cycle
      else if (wb_adr_i == URF_OFS_FRAME)
      begin
        n.frame = wr_word[URF_FRAME_HI:0];
      end
      else if (wb_adr_i == URF_OFS_MARK)
      begin
        n.marking = wr_word[15:0];
      end
    end
    // read data sampled in the request cycle, zero outside the ack cycle
    n.rdat = (req & ~r.ack) ? rd_word : 32'h0000_0000;
  end

  // read mux, also the base of the byte-lane merge on writes
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (wb_adr_i == URF_OFS_CTRL)
    begin
      rd_word[URF_CTRL_DEC_BIT] = r.line_state_decode_enable;
    end
    else if (wb_adr_i == URF_OFS_ADDR)
    begin
      rd_word[6:0] = r.dev_addr;
    end
    else if (wb_adr_i == URF_OFS_FLAGS)
    begin
      rd_word[6:0] = r.flags;
    end
    else if (wb_adr_i == URF_OFS_HOLD)
    begin
      rd_word[6:0] = r.hold;
    end
    else if (wb_adr_i == URF_OFS_MASK)
    begin
      rd_word = r.masks;
    end
    else if (wb_adr_i == URF_OFS_FRAME)
    begin
      rd_word[URF_FRAME_HI:0] = r.frame;
    end
    else if (wb_adr_i == URF_OFS_PID)
    begin
      rd_word[3:0] = r.last_packet_id;
    end
    else if (wb_adr_i == URF_OFS_EP)
    begin
      rd_word[URF_EP_VALID_BIT:0] = {r.ep_valid, r.ep};
    end
    else if (wb_adr_i == URF_OFS_MARK)
    begin
      rd_word[15:0] = r.marking;
    end
  end

  assign wr_word = urf_merge(rd_word, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.flags <= URF_RST_FLAGS;
      r.masks <= URF_RST_MASK;
      r.frame <= URF_RST_FRAME;
      r.marking <= URF_RST_MARK;
      r.dev_addr <= URF_RST_ADDR;
    end
    else
    begin
      r <= n;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdat;
  assign flag_out_port_a_o = r.port[0];
  assign flag_out_port_b_o = r.port[1];
  assign flag_out_port_c_o = r.port[2];
  assign flag_out_port_d_o = r.port[3];
  assign rx_ep_o = r.rx_ep;
  assign rx_ep_valid_o = r.rx_v;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req_open;
    req && !r.ack;
  endsequence
  sequence s_ack_once;
    r.ack ##1 !r.ack;
  endsequence

  a_bus_ack_once: assert property (s_req_open |=> s_ack_once)
    else $error("ack not a single cycle after request");
  a_token_sets_flag: assert property (tok_ok |=> r.flags[URF_F_TOKEN])
    else $error("token flag not set");
  a_addr_filter: assert property (tok_i && tok_addr_i != r.dev_addr |=> !rx_ep_valid_o)
    else $error("foreign token passed on");
  a_rx_port_mark: assert property (tok_ok |=> rx_ep_valid_o && rx_ep_o[3:0] == $past(tok_ep_i)
    && rx_ep_o[4] == $past(mark_bit))
    else $error("receive port endpoint wrong");
  a_ep_valid_set: assert property (tok_ok |=> r.ep_valid && r.ep == $past(tok_ep_i))
    else $error("endpoint copy wrong");
  a_packet_clear: assert property (pkt_start_i && !r.hold[URF_F_CRC] && !ev[URF_F_CRC]
    |=> !r.flags[URF_F_CRC])
    else $error("crc flag kept across packet");
  a_sticky_hold: assert property (r.hold[URF_F_CRC] && r.flags[URF_F_CRC] && !clr[URF_F_CRC]
    ##1 r.hold[URF_F_CRC] |-> r.flags[URF_F_CRC])
    else $error("held flag lost");
  a_rxa_follow: assert property (!r.hold[URF_F_RXA] |=> r.flags[URF_F_RXA] == $past(r.filt[1]))
    else $error("rxactive flag not following");
  a_decode_off: assert property (!r.line_state_decode_enable && !r.hold[URF_F_SE0]
    |=> !r.flags[URF_F_SE0])
    else $error("se0 flag set while decode off");
  a_port_or: assert property (##1 flag_out_port_a_o == $past(|(r.flags & r.masks[URF_NFLAG-1:0])))
    else $error("port a not mask OR of flags");
  a_pid_capture: assert property (pid_valid_i |=> r.last_packet_id == $past(pid_i))
    else $error("packet id not captured");

endmodule // urf_flag_monitor

/* File: urf_pkg.sv */
package urf_pkg;
  localparam int URF_NFLAG = 7;
  localparam logic [7:0] URF_OFS_CTRL = 8'h04;
  localparam logic [7:0] URF_OFS_ADDR = 8'h08;
  localparam logic [7:0] URF_OFS_FLAGS = 8'h1C;
  localparam logic [7:0] URF_OFS_HOLD = 8'h20;
  localparam logic [7:0] URF_OFS_MASK = 8'h24;
  localparam logic [7:0] URF_OFS_FRAME = 8'h28;
  localparam logic [7:0] URF_OFS_PID = 8'h2C;
  localparam logic [7:0] URF_OFS_EP = 8'h30;
  localparam logic [7:0] URF_OFS_MARK = 8'h34;
  localparam int URF_F_TOKEN = 6;
  localparam int URF_F_SE0 = 5;
  localparam int URF_F_K = 4;
  localparam int URF_F_J = 3;
  localparam int URF_F_CRC = 2;
  localparam int URF_F_RXA = 1;
  localparam int URF_F_RXE = 0;
  localparam int URF_CTRL_DEC_BIT = 2;
  localparam int URF_EP_VALID_BIT = 4;
  localparam int URF_FRAME_HI = 10;
  localparam int URF_FRAME_LO_TOP = 7;
  localparam logic [4:0] URF_MARK_OR = 5'h10;
  localparam logic [6:0] URF_LEVEL_FLAGS = 7'h3B;
  localparam logic [1:0] URF_LS_SE0 = 2'h0;
  localparam logic [1:0] URF_LS_J = 2'h1;
  localparam logic [1:0] URF_LS_K = 2'h2;
  localparam logic [6:0] URF_RST_FLAGS = 7'h00;
  localparam logic [31:0] URF_RST_MASK = 32'h0000_0000;
  localparam logic [10:0] URF_RST_FRAME = 11'h000;
  localparam logic [15:0] URF_RST_MARK = 16'h0000;
  localparam logic [6:0] URF_RST_ADDR = 7'h00;
endpackage

/* File: urf_utmi_model.sv */
`timescale 1ns/1ns
module urf_utmi_model
(
  input wire logic clk_i,
  output logic [1:0] ls_o,
  output logic rxa_o,
  output logic rxe_o,
  output logic [4:0] ev_o,
  output logic [10:0] v_o,
  output logic [1:0] ok_o
);
  initial
  begin
    ls_o = 2'h1;
    {rxa_o, rxe_o, ev_o, v_o, ok_o} = 20'h00000;
  end
  // levels held long enough to pass the input synchroniser
  task automatic line(input logic [1:0] ls, input logic a, input logic e);
    @(posedge clk_i);
    ls_o <= ls;
    rxa_o <= a;
    rxe_o <= e;
    repeat (8) @(posedge clk_i);
  endtask
  // one event pulse; k picks packet, pid, token, crc16 or frame
  task automatic pulse(input int k, input logic [10:0] v, input logic [1:0] ok);
    @(posedge clk_i);
    ev_o <= 5'h01 << k;
    v_o <= v;
    ok_o <= ok;
    @(posedge clk_i);
    ev_o <= 5'h00;
    // qualifiers expire with the pulse: junk, not stale values
    v_o <= ~v;
    ok_o <= ~ok;
  endtask
endmodule // urf_utmi_model

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench
  import urf_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic wb_ack_o, flag_out_port_a_o, flag_out_port_b_o, flag_out_port_c_o, flag_out_port_d_o, rx_ep_valid_o;
  logic [4:0] rx_ep_o, ev;
  logic [1:0] utmi_linestate_i, ok;
  logic utmi_rxactive_i, utmi_rxerror_i;
  logic [10:0] v;
  logic [31:0] rd_q[$];
  logic [4:0] ep_q[$];
  integer seed = 32'hA03F029A;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] ofs [9] = '{8'h04, 8'h08, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h3C};
  logic [31:0] msk [9] = '{32'h4, 32'h7F, 32'h7F, 32'hFFFFFFFF, 32'h7FF, 32'h0, 32'h0, 32'hFFFF, 32'h0};
  logic [2:0] lsx [4] = '{3'h4, 3'h1, 3'h2, 3'h0};
  urf_flag_monitor u_urf_flag_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .utmi_linestate_i(utmi_linestate_i), .utmi_rxactive_i(utmi_rxactive_i),
    .utmi_rxerror_i(utmi_rxerror_i), .pkt_start_i(ev[0]), .pid_valid_i(ev[1]), .pid_i(v[3:0]),
    .tok_i(ev[2]), .tok_crc5_ok_i(ok[1]), .tok_pid_ok_i(ok[0]), .tok_addr_i(v[6:0]), .tok_ep_i(v[10:7]),
    .data_crc16_fail_i(ev[3]), .sof_i(ev[4]), .sof_frame_i(v), .flag_out_port_a_o(flag_out_port_a_o),
    .flag_out_port_b_o(flag_out_port_b_o), .flag_out_port_c_o(flag_out_port_c_o),
    .flag_out_port_d_o(flag_out_port_d_o), .rx_ep_o(rx_ep_o), .rx_ep_valid_o(rx_ep_valid_o));
  urf_utmi_model u_urf_utmi_model (.clk_i(clk_i), .ls_o(utmi_linestate_i), .rxa_o(utmi_rxactive_i),
    .rxe_o(utmi_rxerror_i), .ev_o(ev), .v_o(v), .ok_o(ok));
  always #2 clk_i = ~clk_i;
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // an empty queue compares against x, so extra answers fail
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      check("read", wb_dat_o, rd_q.size() ? rd_q.pop_front() : 'x);
    if (rx_ep_valid_o === 1'b1)
      check("rx_ep", rx_ep_o, ep_q.size() ? ep_q.pop_front() : 'x);
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic ports(input logic [3:0] e);
    repeat (3) @(posedge clk_i);
    check("ports", {flag_out_port_a_o, flag_out_port_b_o, flag_out_port_c_o, flag_out_port_d_o}, e);
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_of_test;
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 4; a < 64; a += 4)
      rd(a[7:0], 32'h0);
    ports(4'h0);
    done("reset");
    foreach (ofs[i])
    begin
      wr(ofs[i], 32'hFFFFFFFF);
      rd(ofs[i], msk[i]);
    end
    wr(URF_OFS_CTRL, 32'h0);
    wr(URF_OFS_HOLD, 32'h0);
    wr(URF_OFS_FLAGS, 32'h7F);
    rd(URF_OFS_FLAGS, 32'h0);
    done("regs");
    r = $random(seed);
    wr(URF_OFS_ADDR, {25'h0, r[6:0]});
    wr(URF_OFS_MARK, {16'h0, r[31:16]});
    wr(URF_OFS_MASK, 32'h7F440440);
    u_urf_utmi_model.pulse(2, {r[10:7], r[6:0] ^ 7'h01}, 2'h3);
    u_urf_utmi_model.pulse(2, r[10:0], 2'h1);
    u_urf_utmi_model.pulse(2, r[10:0], 2'h2);
    rd(URF_OFS_FLAGS, 32'h0);
    ep_q.push_back({r[16 + r[10:7]], r[10:7]});
    u_urf_utmi_model.pulse(2, r[10:0], 2'h3);
    rd(URF_OFS_FLAGS, 32'h40);
    rd(URF_OFS_EP, {27'h0, 1'b1, r[10:7]});
    ports(4'hB);
    u_urf_utmi_model.pulse(0, 11'h0, 2'h0);
    rd(URF_OFS_FLAGS, 32'h0);
    ports(4'h0);
    wr(URF_OFS_HOLD, 32'h40);
    ep_q.push_back({r[16 + r[10:7]], r[10:7]});
    u_urf_utmi_model.pulse(2, r[10:0], 2'h3);
    u_urf_utmi_model.pulse(0, 11'h0, 2'h0);
    wr(URF_OFS_FLAGS, 32'h3F);
    rd(URF_OFS_FLAGS, 32'h40);
    wr(URF_OFS_FLAGS, 32'h40);
    rd(URF_OFS_FLAGS, 32'h0);
    done("token");
    wr(URF_OFS_HOLD, 32'h0);
    u_urf_utmi_model.pulse(3, 11'h0, 2'h0);
    rd(URF_OFS_FLAGS, 32'h4);
    ports(4'h7);
    u_urf_utmi_model.pulse(0, 11'h0, 2'h0);
    rd(URF_OFS_FLAGS, 32'h0);
    done("crc");
    u_urf_utmi_model.line(2'h2, 1'b0, 1'b0);
    rd(URF_OFS_FLAGS, 32'h0);
    wr(URF_OFS_CTRL, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      u_urf_utmi_model.line(i[1:0], i[0], i[1]);
      rd(URF_OFS_FLAGS, {25'h0, 1'b0, lsx[i], 1'b0, i[0], i[1]});
    end
    wr(URF_OFS_HOLD, 32'h20);
    u_urf_utmi_model.line(2'h0, 1'b0, 1'b0);
    u_urf_utmi_model.line(2'h1, 1'b0, 1'b0);
    rd(URF_OFS_FLAGS, 32'h28);
    wr(URF_OFS_FLAGS, 32'h20);
    rd(URF_OFS_FLAGS, 32'h08);
    done("line");
    r = $random(seed);
    u_urf_utmi_model.pulse(1, r[10:0], 2'h0);
    rd(URF_OFS_PID, {28'h0, r[3:0]});
    u_urf_utmi_model.pulse(4, r[10:0], 2'h0);
    rd(URF_OFS_FRAME, {21'h0, r[10:0]});
    wr(URF_OFS_FRAME, ~r);
    rd(URF_OFS_FRAME, {21'h0, ~r[10:0]});
    repeat (4) @(posedge clk_i);
    check("left", rd_q.size() + ep_q.size(), 32'h0);
    done("pid_frame");
    end_of_test;
  end
endmodule // testbench
